// >>> testbench/tor_block_test.sv
`timescale 1ns/1ps
module tor_block_test;
  localparam int TC = 4;
  logic        ref_clk, rst_n, valve_app_alt, acc_req, acc_write, acc_done_ff, acc_hit_ff, hit;
  logic [2:0]  mod_addr_sw;
  logic [7:0]  acc_array, sense_input, valve_out_ff;
  logic [14:0] acc_register;
  logic [15:0] acc_wdata, acc_rdata_ff, rd, rd2;
  int          n_mismatch, checks_done, cycles, t0, k, ms, inp;

  tor_block #(.TICK_CYCLES(TC), .TW(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .mod_addr_sw(mod_addr_sw),
    .valve_app_alt(valve_app_alt), .acc_req(acc_req), .acc_write(acc_write), .acc_array(acc_array),
    .acc_register(acc_register), .acc_wdata(acc_wdata), .acc_done_ff(acc_done_ff), .acc_hit_ff(acc_hit_ff),
    .acc_rdata_ff(acc_rdata_ff), .sense_input(sense_input), .valve_out_ff(valve_out_ff));
  tor_host_model u_host (.ref_clk(ref_clk), .acc_req(acc_req), .acc_write(acc_write), .acc_array(acc_array),
    .acc_register(acc_register), .acc_wdata(acc_wdata), .acc_done_ff(acc_done_ff), .acc_hit_ff(acc_hit_ff),
    .acc_rdata_ff(acc_rdata_ff));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [14:0] rg(input logic [2:0] a, input logic [11:0] i);
    return (15'(a) << 12) | 15'(i);
  endfunction

  function automatic logic [15:0] ovr_def(input int idx, input logic alt);
    case (idx)
      0, 3: return alt ? 16'h0007 : 16'h0001;
      1, 2: return alt ? 16'h0006 : 16'h0002;
      default: return 16'h00FF;
    endcase
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles > 20000) begin
        n_mismatch++;
        finish_test();
      end
    end
  end

  initial begin
    {rst_n, valve_app_alt, mod_addr_sw, sense_input} = '0;
    void'($urandom(42249));
    for (int alt = 0; alt < 2; alt++) begin
      @(negedge ref_clk);
      rst_n = 1'b0;
      valve_app_alt = alt[0];
      mod_addr_sw = alt[0] ? 3'h7 : 3'h0;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      for (int j = 0; j < 8; j++) begin
        u_host.access(0, tor_pkg::ARR_OVERRIDE, rg(mod_addr_sw, 12'(j)), 16'h0, rd, hit);
        check(rd, ovr_def(j, alt[0]));
        u_host.access(0, tor_pkg::ARR_ACTIVE_CFG, rg(mod_addr_sw, 12'(j)), 16'h0, rd, hit);
        check(rd, 16'h0001);
      end
      u_host.access(1, tor_pkg::ARR_ONTIME, rg(mod_addr_sw + 3'h1, 12'h0), 16'h0005, rd, hit);
      check({15'h0, hit}, 16'h0000);
      check(rd, 16'h0000);
      check({8'h00, valve_out_ff}, 16'h0000);
    end
    mod_addr_sw = 3'($urandom_range(7));
    for (int n = 0; n < 4; n++) begin
      k = (n == 0) ? 0 : int'($urandom_range(7));
      ms = $urandom_range(6, 3);
      u_host.access(1, tor_pkg::ARR_ONTIME, rg(mod_addr_sw, 12'(k)), 16'(ms), rd, hit);
      t0 = cycles;
      check({15'h0, hit}, 16'h0001);
      check({8'h00, valve_out_ff}, 16'h0001 << (7 - k));
      u_host.access(0, tor_pkg::ARR_OUT_STATE, rg(mod_addr_sw, 12'(k)), 16'h0, rd, hit);
      check(rd, 16'h0001);
      u_host.access(0, tor_pkg::ARR_ONTIME, rg(mod_addr_sw, tor_pkg::IDX_WAIT_LO + 12'(k)), 16'h0, rd, hit);
      check(rd, 16'h0000);
      check(16'(cycles - t0 >= (ms - 1) * TC && cycles - t0 <= (ms + 1) * TC + 2), 16'h0001);
      check({8'h00, valve_out_ff}, 16'h0000);
    end
    sense_input = 8'($urandom);
    for (int j = 0; j < 8; j++) begin
      u_host.access(0, tor_pkg::ARR_IN_STATE, rg(mod_addr_sw, 12'(j)), 16'h0, rd, hit);
      check(rd, {15'h0, sense_input[7 - j]});
    end
    sense_input = 8'h00;
    k = $urandom_range(7);
    u_host.access(1, tor_pkg::ARR_ACTIVE_CFG, rg(mod_addr_sw, 12'(k)), 16'h0000, rd, hit);
    check({8'h00, valve_out_ff}, 16'h0001 << (7 - k));
    u_host.access(0, tor_pkg::ARR_ACTIVE_CFG, rg(mod_addr_sw, 12'(k)), 16'h0, rd, hit);
    check(rd, 16'h0000);
    u_host.access(1, tor_pkg::ARR_ACTIVE_CFG, rg(mod_addr_sw, 12'(k)), 16'h0001, rd, hit);
    check({8'h00, valve_out_ff}, 16'h0000);
    // Outputs 1 and 4 first, then one drawn at random
    for (int n = 0; n < 3; n++) begin
      sense_input = 8'h00;
      k = (n == 0) ? 7 : (n == 1) ? 4 : int'($urandom_range(7));
      inp = $urandom_range(8, 1);
      u_host.access(1, tor_pkg::ARR_OVERRIDE, rg(mod_addr_sw, 12'(k)), 16'(inp), rd, hit);
      u_host.access(0, tor_pkg::ARR_OVERRIDE, rg(mod_addr_sw, 12'(k)), 16'h0, rd, hit);
      check(rd, 16'(inp));
      u_host.access(1, tor_pkg::ARR_ONTIME, rg(mod_addr_sw, 12'(k)), 16'h0014, rd, hit);
      repeat (5 * TC) @(negedge ref_clk);
      sense_input[inp - 1] = 1'b1;
      u_host.access(0, tor_pkg::ARR_ONTIME, rg(mod_addr_sw, tor_pkg::IDX_WAIT_LO + 12'(k)), 16'h0, rd, hit);
      u_host.access(0, tor_pkg::ARR_ONTIME, rg(mod_addr_sw, tor_pkg::IDX_RESID_LO + 12'(k)), 16'h0, rd2, hit);
      check(rd2, rd);
      check(16'(rd >= 16'h000E && rd <= 16'h0010), 16'h0001);
      check({8'h00, valve_out_ff}, 16'h0000);
    end
    finish_test();
  end
endmodule

// >>> testbench/tor_host_model.sv
`timescale 1ns/1ps
module tor_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Request side
  output logic             acc_req,
  output logic             acc_write,
  output logic [7:0]       acc_array,
  output logic [14:0]      acc_register,
  output logic [15:0]      acc_wdata,
  // Answer side
  input  wire logic        acc_done_ff,
  input  wire logic        acc_hit_ff,
  input  wire logic [15:0] acc_rdata_ff
);
  initial begin
    {acc_req, acc_write, acc_array, acc_register, acc_wdata} = '0;
  end

  // One access, held until the answer edge
  task automatic access(input logic wr, input logic [7:0] arr, input logic [14:0] rg, input logic [15:0] wd,
                        output logic [15:0] rd, output logic hit);
    @(negedge ref_clk);
    {acc_write, acc_array, acc_register, acc_wdata} = {wr, arr, rg, wd};
    acc_req = 1'b1;
    // A hang here is caught by the bench's cycle ceiling
    do begin
      @(negedge ref_clk);
    end while (acc_done_ff !== 1'b1);
    rd = acc_rdata_ff;
    hit = acc_hit_ff;
    // Hold the request over the edge that samples the answer
    @(posedge ref_clk);
    @(negedge ref_clk);
    acc_req = 1'b0;
    // Released lines do not keep their last value
    {acc_write, acc_array, acc_register, acc_wdata} = ~{acc_write, acc_array, acc_register, acc_wdata};
  endtask
endmodule

// >>> verilog/tor_block.sv
`timescale 1ns/1ps
module tor_block #(
  parameter int TICK_CYCLES = tor_pkg::TICK_CYCLES,
  parameter int TW          = 16
) (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // Straps
  input  wire logic [2:0]     mod_addr_sw,
  input  wire logic           valve_app_alt,
  // Point access
  input  wire logic           acc_req,
  input  wire logic           acc_write,
  input  wire logic [7:0]     acc_array,
  input  wire logic [14:0]    acc_register,
  input  wire logic [TW-1:0]  acc_wdata,
  output logic                acc_done_ff,
  output logic                acc_hit_ff,
  output logic [TW-1:0]       acc_rdata_ff,
  // Field pins, bit n-1 is output or input n
  input  wire logic [7:0]     sense_input,
  output logic [7:0]          valve_out_ff
);
  // Override numbers are eight bits wide, so narrower data cannot hold them
  if (TICK_CYCLES < 1 || TW < 8) begin : g_bad_param
    $error("tor_block: bad parameter");
  end

  // Index k of a block of eight maps to point 8-k, held at bit 7-k
  function automatic logic [2:0] pt(input logic [11:0] idx);
    pt = 3'(3'h7 - idx[2:0]);
  endfunction

  logic [TW-1:0] remain_ff  [8];
  logic [TW-1:0] resid_ff   [8];
  logic [7:0]    ovr_ff     [8];
  logic [7:0]    run_ff;
  logic [7:0]    act_cfg_ff;
  logic [31:0]   tick_cnt_ff;
  logic          tick_ff;
  logic          pend_ff;
  logic [2:0]    pend_pt_ff;

  wire logic [11:0] idx   = acc_register[11:0];
  wire logic        mine  = acc_register[14:12] == mod_addr_sw;
  wire logic        take  = acc_req && !pend_ff && !acc_done_ff;
  wire logic        c_wr  = take && mine && acc_write;
  wire logic        c_rd  = take && mine && !acc_write;

  // Millisecond time base
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
      tick_ff     <= 1'b0;
    end
  end

  // Override hit per output: assigned input number 1..8 is active
  logic [7:0] ovr_hit;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ovr_hit[i] = (ovr_ff[i] >= 8'h01) && (ovr_ff[i] <= 8'h08) && sense_input[3'(ovr_ff[i] - 8'h01)];
    end
  end

  // On-timers, residual capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_ff <= '0;
      for (int i = 0; i < 8; i++) begin
        remain_ff[i] <= '0;
        resid_ff[i]  <= '0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (c_wr && acc_array == tor_pkg::ARR_ONTIME && idx < tor_pkg::IDX_WAIT_LO && pt(idx) == 3'(i)) begin
          remain_ff[i] <= acc_wdata;
          run_ff[i]    <= acc_wdata != '0;
          resid_ff[i]  <= '0;
        end else if (run_ff[i] && ovr_hit[i]) begin
          run_ff[i]   <= 1'b0;
          resid_ff[i] <= remain_ff[i];
          remain_ff[i] <= '0;
        end else if (run_ff[i] && tick_ff) begin
          remain_ff[i] <= remain_ff[i] - TW'(1);
          if (remain_ff[i] == TW'(1)) begin
            run_ff[i]   <= 1'b0;
            resid_ff[i] <= '0;
          end
        end
      end
    end
  end

  // Override assignment and active-state configuration
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovr_ff[7]  <= valve_app_alt ? tor_pkg::OVR_ALT_A : tor_pkg::OVR_DEF_A;
      ovr_ff[6]  <= valve_app_alt ? tor_pkg::OVR_ALT_B : tor_pkg::OVR_DEF_B;
      ovr_ff[5]  <= valve_app_alt ? tor_pkg::OVR_ALT_B : tor_pkg::OVR_DEF_B;
      ovr_ff[4]  <= valve_app_alt ? tor_pkg::OVR_ALT_A : tor_pkg::OVR_DEF_A;
      for (int i = 0; i < 4; i++) ovr_ff[i] <= tor_pkg::OVR_NONE;
      act_cfg_ff <= tor_pkg::ACTIVE_CFG_RST;
    end else if (c_wr && idx < tor_pkg::IDX_WAIT_LO) begin
      if (acc_array == tor_pkg::ARR_OVERRIDE) ovr_ff[pt(idx)] <= acc_wdata[7:0];
      if (acc_array == tor_pkg::ARR_ACTIVE_CFG) act_cfg_ff[pt(idx)] <= acc_wdata[0];
    end
  end

  // Pins show the configured active level while running
  always_ff @(posedge ref_clk) begin
    if (!rst_n) valve_out_ff <= '0;
    else valve_out_ff <= ~(run_ff ^ act_cfg_ff) & act_cfg_ff | run_ff & act_cfg_ff | ~run_ff & ~act_cfg_ff;
  end

  // Access answer, with held-off reads of the waiting residual
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_done_ff  <= 1'b0;
      acc_hit_ff   <= 1'b0;
      acc_rdata_ff <= '0;
      pend_ff      <= 1'b0;
      pend_pt_ff   <= '0;
    end else begin
      acc_done_ff <= 1'b0;
      if (acc_done_ff) begin
        acc_hit_ff <= acc_hit_ff;
      end else if (pend_ff) begin
        if (!run_ff[pend_pt_ff]) begin
          pend_ff      <= 1'b0;
          acc_done_ff  <= 1'b1;
          acc_rdata_ff <= resid_ff[pend_pt_ff];
        end
      end else if (take && !mine) begin
        acc_done_ff <= 1'b1;
        acc_hit_ff  <= 1'b0;
        acc_rdata_ff <= '0;
      end else if (c_wr) begin
        acc_done_ff <= 1'b1;
        acc_hit_ff  <= 1'b1;
      end else if (c_rd) begin
        acc_hit_ff   <= 1'b1;
        acc_rdata_ff <= '0;
        acc_done_ff  <= 1'b1;
        case (acc_array)
          tor_pkg::ARR_ONTIME: begin
            if (idx < tor_pkg::IDX_WAIT_LO) begin
              acc_rdata_ff <= remain_ff[pt(idx)];
            end else if (idx < tor_pkg::IDX_RESID_LO) begin
              acc_done_ff <= 1'b0;
              pend_ff     <= 1'b1;
              pend_pt_ff  <= pt(idx);
            end else if (idx < tor_pkg::IDX_RESID_END) begin
              acc_rdata_ff <= resid_ff[pt(idx)];
            end
          end
          tor_pkg::ARR_OVERRIDE:   if (idx < tor_pkg::IDX_WAIT_LO) acc_rdata_ff <= TW'(ovr_ff[pt(idx)]);
          tor_pkg::ARR_ACTIVE_CFG: if (idx < tor_pkg::IDX_WAIT_LO) acc_rdata_ff <= TW'(act_cfg_ff[pt(idx)]);
          tor_pkg::ARR_OUT_STATE:  if (idx < tor_pkg::IDX_WAIT_LO) acc_rdata_ff <= TW'(run_ff[pt(idx)]);
          tor_pkg::ARR_IN_STATE:   if (idx < tor_pkg::IDX_WAIT_LO) acc_rdata_ff <= TW'(sense_input[pt(idx)]);
          default: acc_rdata_ff <= '0;
        endcase
      end
    end
  end

  property p_timer_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (c_wr && acc_array == tor_pkg::ARR_ONTIME && idx == 12'h000 && acc_wdata != '0) |=> run_ff[7];
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("on-time write did not start output 8");

  property p_override_ends;
    @(posedge ref_clk) disable iff (!rst_n)
      (run_ff[0] && ovr_hit[0] && !c_wr) |=> !run_ff[0] && resid_ff[0] == $past(remain_ff[0]);
  endproperty
  a_override_ends: assert property (p_override_ends) else $error("override did not capture residual");

  property p_wait_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (pend_ff && run_ff[pend_pt_ff]) |=> !acc_done_ff;
  endproperty
  a_wait_read: assert property (p_wait_read) else $error("held read answered while timer runs");

  property p_foreign;
    @(posedge ref_clk) disable iff (!rst_n)
      (take && !mine) |=> acc_done_ff && !acc_hit_ff;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address group answered as hit");

  property p_resid_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (c_rd && acc_array == tor_pkg::ARR_ONTIME && idx == 12'h017) |=> acc_done_ff && acc_rdata_ff == $past(resid_ff[0]);
  endproperty
  a_resid_read: assert property (p_resid_read) else $error("residual read wrong");

  property p_in_state;
    @(posedge ref_clk) disable iff (!rst_n)
      (c_rd && acc_array == tor_pkg::ARR_IN_STATE && idx == 12'h007) |=> acc_rdata_ff == TW'($past(sense_input[0]));
  endproperty
  a_in_state: assert property (p_in_state) else $error("input state read wrong");

  property p_pin;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> valve_out_ff == ~($past(run_ff) ^ $past(act_cfg_ff));
  endproperty
  a_pin: assert property (p_pin) else $error("output pin level wrong");

  property p_ovr_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (c_wr && acc_array == tor_pkg::ARR_OVERRIDE && idx == 12'h004) |=> ovr_ff[3] == $past(acc_wdata[7:0]);
  endproperty
  a_ovr_write: assert property (p_ovr_write) else $error("override write lost");
endmodule

// >>> verilog/tor_pkg.sv
package tor_pkg;
  localparam int          ADDR_SHIFT      = 12;
  localparam int          GROUP_SIZE      = 4096;
  localparam logic [7:0]  ARR_ONTIME      = 8'hC0;
  localparam logic [7:0]  ARR_OVERRIDE    = 8'hC1;
  localparam logic [7:0]  ARR_ACTIVE_CFG  = 8'hC2;
  localparam logic [7:0]  ARR_OUT_STATE   = 8'hC4;
  localparam logic [7:0]  ARR_IN_STATE    = 8'hC5;
  localparam logic [11:0] IDX_ONTIME_LO   = 12'h000;
  localparam logic [11:0] IDX_WAIT_LO     = 12'h008;
  localparam logic [11:0] IDX_RESID_LO    = 12'h010;
  localparam logic [7:0]  OVR_NONE        = 8'hFF;
  localparam logic [7:0]  OVR_DEF_A       = 8'h01;
  localparam logic [7:0]  OVR_DEF_B       = 8'h02;
  localparam logic [7:0]  OVR_ALT_A       = 8'h07;
  localparam logic [7:0]  OVR_ALT_B       = 8'h06;
  localparam logic [11:0] IDX_RESID_END   = 12'h018;
  localparam logic [7:0]  ACTIVE_CFG_RST  = 8'hFF;
  localparam int          TICK_MS         = 1;
  localparam int          CLK_KHZ         = 50000;
  localparam int          TICK_CYCLES     = TICK_MS * CLK_KHZ;
endpackage
